// File: design/ugc_pkg.sv
`default_nettype none
package ugc_pkg;

    // Command codes
    localparam logic [7:0] CMD_STATUS_BASE  = 8'ha0;
    localparam logic [3:0] CMD_STATUS_HI    = 4'ha;
    localparam logic [7:0] CMD_UNLOCK       = 8'hb0;
    localparam logic [7:0] CMD_SCRATCH_WR   = 8'hb2;
    localparam logic [7:0] CMD_SCRATCH_RD   = 8'hb3;
    localparam logic [15:0] UNLOCK_KEY      = 16'haa37;

    // Status byte layout
    localparam int ST_OVERRUN_BIT = 7;
    localparam int ST_PID_BIT     = 6;
    localparam int ST_ERR_LSB     = 1;
    localparam int ST_OK_BIT      = 0;
    localparam int ST_RSVD_BIT    = 5;
    // Read mask forces the reserved bit low
    localparam logic [7:0] ST_RD_MASK = 8'hdf;

    // Scratch layout
    localparam int SCR_W = 13;
    localparam logic [SCR_W-1:0] SCR_RESET = 13'h0000;

    // Transaction error codes
    localparam logic [3:0] ERR_NONE      = 4'h0;
    localparam logic [3:0] ERR_PID_ENC   = 4'h1;
    localparam logic [3:0] ERR_PID_UNK   = 4'h2;
    localparam logic [3:0] ERR_UNEXP     = 4'h3;
    localparam logic [3:0] ERR_TOK_CRC   = 4'h4;
    localparam logic [3:0] ERR_DAT_CRC   = 4'h5;
    localparam logic [3:0] ERR_TIMEOUT   = 4'h6;
    localparam logic [3:0] ERR_BABBLE    = 4'h7;
    localparam logic [3:0] ERR_EOP       = 4'h8;
    localparam logic [3:0] ERR_NAK       = 4'h9;
    localparam logic [3:0] ERR_STALL     = 4'ha;
    localparam logic [3:0] ERR_OVERFLOW  = 4'hb;
    localparam logic [3:0] ERR_ISO_EMPTY = 4'hc;
    localparam logic [3:0] ERR_STUFF     = 4'hd;
    localparam logic [3:0] ERR_SYNC      = 4'he;
    localparam logic [3:0] ERR_TOGGLE    = 4'hf;

    // Transaction report from the serial engine
    typedef struct packed {
        logic [3:0] ep;
        logic       pid_data1;
        logic [3:0] err;
        logic       ok;
    } ugc_txn_s;

    // Host bus cycle
    typedef struct packed {
        logic       cmd_wr;
        logic       data_wr;
        logic       data_rd;
        logic [7:0] wdata;
    } ugc_bus_s;

endpackage
`default_nettype wire

// File: design/ugc_general_cmds.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Commands A0h-AFh read endpoint status
// - New transaction replaces endpoint status byte
// - One byte read returns selected status
// - Bit 7 set on status_overrun_flag overwrite
// - Bit 6 gives PID of last successful data packet
// - Bits 4:1 error code, bit 5 reserved
// - Bit 0 set on successful transfer
// - Codes 0000, 0001, 0100, 0101
// - Codes 0010, 0110, 0111
// - Codes 0011 unexpected, 1000 early EOP
// - Codes 1001 NAK, 1101 stuff, 1110 sync
// - Code 1010 stall handshake sent
// - Code 1011 buffer overflow
// - Code 1100 empty ISO packet
// - Code 1111 bad toggle, data dropped
// - Writes blocked in suspend until unlock
// - Reads blocked after suspend until unlock
// - Unlock value low byte first
// - Exactly AA37h removes write protection
// - B2h writes, B3h reads scratch
// - Scratch bits 12:0 storage, reset zero
module ugc_general_cmds #(
    parameter int N_EP = 16
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst,
    input  wire ugc_pkg::ugc_bus_s i_bus,
    input  wire logic              i_txn_done,
    input  wire ugc_pkg::ugc_txn_s i_txn,
    input  wire logic              i_suspend,
    output logic [7:0]             o_rdata,
    output logic                   o_rdata_valid,
    output logic                   o_write_locked,
    output logic                   o_read_locked
);

    typedef enum logic [4:0] {
        ST_IDLE   = 5'b00001,
        ST_STATRD = 5'b00010,
        ST_UNLK   = 5'b00100,
        ST_SCRWR  = 5'b01000,
        ST_SCRRD  = 5'b10000
    } ugc_state_e;

    ugc_state_e         state_q;
    logic               byte_hi_q;
    logic [7:0]         key_lo_q;
    logic [3:0]         ep_sel_q;
    logic [7:0]         status_q [N_EP];
    logic               locked_q;
    logic [ugc_pkg::SCR_W-1:0] scratch_q;
    logic [7:0]         scr_lo_q;
    logic               pending_q [N_EP];

    function automatic logic is_status_cmd(input logic [7:0] c);
        is_status_cmd = (c[7:4] == ugc_pkg::CMD_STATUS_HI);
    endfunction

    wire logic stat_read = (state_q == ST_STATRD) && i_bus.data_rd;

    // Status read aimed at one endpoint
    function automatic logic ep_read(input int e);
        ep_read = stat_read && (ep_sel_q == 4'(e));
    endfunction

    // Full key compare, high byte arrives last
    function automatic logic key_match(input logic [7:0] hi, input logic [7:0] lo);
        key_match = ({hi, lo} == ugc_pkg::UNLOCK_KEY);
    endfunction

    // Command decode and byte sequencing
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_q   <= ST_IDLE;
            byte_hi_q <= 1'b0;
            ep_sel_q  <= 4'h0;
        end else if (i_bus.cmd_wr) begin
            byte_hi_q <= 1'b0;
            ep_sel_q  <= i_bus.wdata[3:0];
            if (is_status_cmd(i_bus.wdata)) begin
                state_q <= ST_STATRD;
            end else if (i_bus.wdata == ugc_pkg::CMD_UNLOCK) begin
                state_q <= ST_UNLK;
            end else if (i_bus.wdata == ugc_pkg::CMD_SCRATCH_WR) begin
                state_q <= ST_SCRWR;
            end else if (i_bus.wdata == ugc_pkg::CMD_SCRATCH_RD) begin
                state_q <= ST_SCRRD;
            end else begin
                state_q <= ST_IDLE;
            end
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                end
                ST_STATRD: begin
                    if (i_bus.data_rd) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_UNLK, ST_SCRWR: begin
                    if (i_bus.data_wr) begin
                        byte_hi_q <= ~byte_hi_q;
                        if (byte_hi_q) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_SCRRD: begin
                    if (i_bus.data_rd) begin
                        byte_hi_q <= ~byte_hi_q;
                        if (byte_hi_q) begin
                            state_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Per endpoint status store; a completing transaction outranks a read
    for (genvar e = 0; e < N_EP; e++) begin : g_ep
        always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
                status_q[e]  <= 8'h00;
                pending_q[e] <= 1'b0;
            end else if (i_txn_done && i_txn.ep == 4'(e)) begin
                status_q[e][ugc_pkg::ST_OK_BIT]     <= i_txn.ok;
                status_q[e][ugc_pkg::ST_ERR_LSB+:4] <= i_txn.err;
                status_q[e][ugc_pkg::ST_RSVD_BIT]   <= 1'b0;
                // Keep last good PID type when this one failed
                if (i_txn.ok) begin
                    status_q[e][ugc_pkg::ST_PID_BIT] <= i_txn.pid_data1;
                end
                // Overrun only if the old status was never read; a read now still saw it
                status_q[e][ugc_pkg::ST_OVERRUN_BIT] <= status_q[e][ugc_pkg::ST_OVERRUN_BIT]
                                                        | (pending_q[e] & ~ep_read(e));
                pending_q[e] <= 1'b1;
            end else if (ep_read(e)) begin
                status_q[e][ugc_pkg::ST_OVERRUN_BIT] <= 1'b0;
                pending_q[e] <= 1'b0;
            end
        end
    end

    // Unlock key: low byte first, full match only
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            locked_q <= 1'b0;
            key_lo_q <= 8'h00;
        end else if (i_suspend) begin
            locked_q <= 1'b1;
        end else if (state_q == ST_UNLK && i_bus.data_wr && !i_bus.cmd_wr) begin
            if (!byte_hi_q) begin
                key_lo_q <= i_bus.wdata;
            end else if (key_match(i_bus.wdata, key_lo_q)) begin
                locked_q <= 1'b0;
            end
        end
    end

    // Scratch store; writes ignored while locked
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            scratch_q <= ugc_pkg::SCR_RESET;
            scr_lo_q  <= 8'h00;
        end else if (state_q == ST_SCRWR && i_bus.data_wr && !i_bus.cmd_wr && !locked_q) begin
            if (!byte_hi_q) begin
                scr_lo_q <= i_bus.wdata;
            end else begin
                scratch_q <= {i_bus.wdata[ugc_pkg::SCR_W-9:0], scr_lo_q};
            end
        end
    end

    // Read data; locked reads return zero
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata       <= 8'h00;
            o_rdata_valid <= 1'b0;
        end else begin
            o_rdata_valid <= 1'b0;
            if (i_bus.data_rd && !i_bus.cmd_wr) begin
                o_rdata_valid <= 1'b1;
                if (locked_q) begin
                    o_rdata <= 8'h00;
                end else if (state_q == ST_STATRD) begin
                    o_rdata <= status_q[ep_sel_q] & ugc_pkg::ST_RD_MASK;
                end else if (state_q == ST_SCRRD) begin
                    o_rdata <= byte_hi_q ? {3'b000, scratch_q[ugc_pkg::SCR_W-1:8]} : scratch_q[7:0];
                end else begin
                    o_rdata <= 8'h00;
                end
            end
        end
    end

    // Lock state outputs
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_write_locked <= 1'b0;
            o_read_locked  <= 1'b0;
        end else begin
            o_write_locked <= locked_q;
            o_read_locked  <= locked_q;
        end
    end

    a_scr_rst_zero: assert property (@(posedge i_ref_clk) $fell(i_rst) |-> scratch_q == '0)
        else $error("scratch not zero after reset");
    a_suspend_locks: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_suspend |=> locked_q)
        else $error("suspend did not lock");
    a_lock_out: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        locked_q |=> o_write_locked && o_read_locked)
        else $error("lock outputs lag");
    a_bad_key_keeps: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (locked_q && !i_suspend && !(state_q == ST_UNLK && byte_hi_q && i_bus.data_wr
         && {i_bus.wdata, key_lo_q} == ugc_pkg::UNLOCK_KEY)) |=> locked_q)
        else $error("unlocked without key");
    a_good_key: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!i_suspend && !i_bus.cmd_wr && state_q == ST_UNLK && byte_hi_q && i_bus.data_wr
         && {i_bus.wdata, key_lo_q} == ugc_pkg::UNLOCK_KEY) |=> !locked_q)
        else $error("key did not unlock");
    a_locked_read_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (locked_q && i_bus.data_rd && !i_bus.cmd_wr) |=> o_rdata_valid && o_rdata == 8'h00)
        else $error("read leaked while locked");
    a_status_cmd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_bus.cmd_wr && i_bus.wdata[7:4] == ugc_pkg::CMD_STATUS_HI) |=> state_q == ST_STATRD)
        else $error("status command not decoded");
    a_txn_stores: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_txn_done |=> status_q[$past(i_txn.ep)][4:1] == $past(i_txn.err)
                       && status_q[$past(i_txn.ep)][0] == $past(i_txn.ok))
        else $error("status not replaced");
    a_overrun_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_txn_done && status_q[i_txn.ep][7]) |=> status_q[$past(i_txn.ep)][7])
        else $error("overrun flag lost");
    a_one_read: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (stat_read && !i_bus.cmd_wr) |=> state_q == ST_IDLE)
        else $error("status read not single byte");
    // First write after a read must not look like an overrun
    a_first_no_overrun: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_txn_done && !pending_q[i_txn.ep] && !status_q[i_txn.ep][7]) |=> !status_q[$past(i_txn.ep)][7])
        else $error("overrun flag without status_overrun_flag status");
    // A status read clears the overrun flag
    a_overrun_clear: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (stat_read && !(i_txn_done && i_txn.ep == ep_sel_q)) |=> !status_q[$past(ep_sel_q)][7])
        else $error("overrun flag not cleared by read");
    // Fresh status counts as status_overrun_flag
    a_pending_set: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        i_txn_done |=> pending_q[$past(i_txn.ep)])
        else $error("new status not marked status_overrun_flag");
    // PID type follows successful packets only
    a_pid_new: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_txn_done && i_txn.ok) |=> status_q[$past(i_txn.ep)][6] == $past(i_txn.pid_data1))
        else $error("pid type not taken");
    a_pid_kept: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_txn_done && !i_txn.ok) |=> status_q[$past(i_txn.ep)][6] == $past(status_q[i_txn.ep][6]))
        else $error("pid type changed by failed packet");
    // Status byte reaches the bus with reserved bit low
    a_rdata_status: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (stat_read && !i_bus.cmd_wr && !locked_q)
        |=> o_rdata == ($past(status_q[ep_sel_q]) & ugc_pkg::ST_RD_MASK))
        else $error("status byte wrong");
    a_bit5_zero: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (stat_read && !i_bus.cmd_wr) |=> o_rdata[5] == 1'b0)
        else $error("reserved status bit set");
    // Every read without a command write in the same cycle answers once, one cycle later
    a_rd_valid: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (i_bus.data_rd && !i_bus.cmd_wr) |=> o_rdata_valid)
        else $error("read not answered");
    a_no_stray_valid: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (!i_bus.data_rd || i_bus.cmd_wr) |=> !o_rdata_valid)
        else $error("valid without read");
    // Locked scratch never moves
    a_scr_locked: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        locked_q |=> $stable(scratch_q))
        else $error("scratch written while locked");
    // High scratch byte reads reserved bits as zero
    a_scr_hi_top: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        (state_q == ST_SCRRD && byte_hi_q && i_bus.data_rd && !i_bus.cmd_wr) |=> o_rdata[7:5] == 3'b000)
        else $error("scratch reserved bits set");
    // Only the full key frees the lock
    a_unlock_cause: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $fell(locked_q) |-> $past(state_q == ST_UNLK && byte_hi_q && i_bus.data_wr && !i_bus.cmd_wr
                                  && key_match(i_bus.wdata, key_lo_q)))
        else $error("lock freed without key");
    a_wlock_level: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        !locked_q |=> !o_write_locked)
        else $error("write lock output stuck");

    c_unlock: cover property (@(posedge i_ref_clk) $fell(locked_q));
    c_overrun: cover property (@(posedge i_ref_clk) i_txn_done && status_q[i_txn.ep][7]);
    c_scr_write: cover property (@(posedge i_ref_clk) $changed(scratch_q));
    c_stat_read: cover property (@(posedge i_ref_clk) stat_read);
    c_bad_key: cover property (@(posedge i_ref_clk)
        state_q == ST_UNLK && byte_hi_q && i_bus.data_wr && !key_match(i_bus.wdata, key_lo_q));

endmodule
`default_nettype wire

// File: sim/ugc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// Processor side of the command bus, one strobe pulse per bus cycle
module ugc_host_model (
    input  wire logic             i_ref_clk,
    output var ugc_pkg::ugc_bus_s o_bus
);
    initial o_bus = '0;

    // Strobe for one cycle, then idle, so no strobe ever merges with the next
    task automatic op(input logic [2:0] kind, input logic [7:0] b);
        @(posedge i_ref_clk);
        o_bus <= {kind, b};
        @(posedge i_ref_clk);
        o_bus <= '0;
    endtask

    task automatic cmd(input logic [7:0] c);
        op(3'b100, c);
    endtask

    // Exactly one byte read follows a status command
    task automatic rd1();
        op(3'b001, 8'h00);
    endtask

    // Key goes out low byte first
    task automatic unlock(input logic [15:0] key);
        cmd(ugc_pkg::CMD_UNLOCK);
        op(3'b010, key[7:0]);
        op(3'b010, key[15:8]);
    endtask

    // Reserved top bits always written as zero
    task automatic scr_wr(input logic [12:0] v);
        cmd(ugc_pkg::CMD_SCRATCH_WR);
        op(3'b010, v[7:0]);
        op(3'b010, {3'b000, v[12:8]});
    endtask
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic              i_ref_clk;
    logic              i_rst;
    logic              txn_done;
    logic              suspend;
    ugc_pkg::ugc_txn_s txn;
    ugc_pkg::ugc_bus_s bus;
    logic [7:0]        rdata;
    logic              rvalid;
    logic              wlock;
    logic              rlock;
    logic [7:0]        exp_q[$];
    int                mismatches = 0;
    int                tests_run = 0;
    logic [31:0]       seed = 32'd52007;
    logic [12:0]       scr;

    ugc_host_model mp (.i_ref_clk(i_ref_clk), .o_bus(bus));
    ugc_general_cmds dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus(bus), .i_txn_done(txn_done),
        .i_txn(txn), .i_suspend(suspend), .o_rdata(rdata), .o_rdata_valid(rvalid),
        .o_write_locked(wlock), .o_read_locked(rlock));

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Serial engine report, one-cycle pulse
    task automatic txn_go(input logic [3:0] ep, input logic [3:0] err, input logic ok, input logic pid);
        @(posedge i_ref_clk);
        txn_done <= 1'b1;
        txn <= '{ep: ep, pid_data1: pid, err: err, ok: ok};
        @(posedge i_ref_clk);
        txn_done <= 1'b0;
    endtask

    // Note the byte first, so the monitor always finds it waiting
    task automatic rd_exp(input logic [7:0] e);
        exp_q.push_back(e);
        mp.rd1();
    endtask

    // Every valid pulse consumes the oldest note
    always @(posedge i_ref_clk) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() == 0)
                chk("stray read", 8'h00, 8'hff);
            else
                chk("rdata", exp_q.pop_front(), rdata);
        end
    end

    initial begin
        #50000;
        mismatches++;
        $display("watchdog expired");
        summarize();
    end

    initial begin
        logic [31:0] r;
        logic        ok;
        i_rst = 1'b1;
        txn_done = 1'b0;
        txn = '0;
        suspend = 1'b0;
        repeat (6) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(posedge i_ref_clk);
        #1;
        chk("wlock reset", 8'h00, {7'b0, wlock});
        chk("rlock reset", 8'h00, {7'b0, rlock});
        // Scratch round trip, low byte first
        scr = 13'(xs());
        mp.scr_wr(scr);
        mp.cmd(ugc_pkg::CMD_SCRATCH_RD);
        rd_exp(scr[7:0]);
        rd_exp({3'b000, scr[12:8]});
        $display("scratch test done");
        // Every endpoint once, each with its own error code
        for (int i = 0; i < 16; i++) begin
            r = xs();
            ok = (i == 0);
            txn_go(4'(i), 4'(i), ok, r[0]);
            mp.cmd(ugc_pkg::CMD_STATUS_BASE | 8'(i));
            rd_exp({1'b0, ok & r[0], 1'b0, 4'(i), ok});
        end
        $display("status test done");
        // Status_overrun_flag overwrite sets bit 7, read clears it, PID of last success kept
        txn_go(4'h5, ugc_pkg::ERR_NONE, 1'b1, 1'b1);
        txn_go(4'h5, ugc_pkg::ERR_NAK, 1'b0, 1'b0);
        mp.cmd(8'ha5);
        rd_exp({3'b110, ugc_pkg::ERR_NAK, 1'b0});
        mp.cmd(8'ha5);
        rd_exp({3'b010, ugc_pkg::ERR_NAK, 1'b0});
        $display("overrun test done");
        // Suspend locks, wrong key keeps lock, right key frees it
        @(posedge i_ref_clk);
        suspend <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        suspend <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        #1;
        chk("wlock", 8'h01, {7'b0, wlock});
        chk("rlock", 8'h01, {7'b0, rlock});
        mp.scr_wr(~scr);
        mp.cmd(ugc_pkg::CMD_SCRATCH_RD);
        rd_exp(8'h00);
        rd_exp(8'h00);
        mp.cmd(8'ha5);
        rd_exp(8'h00);
        mp.unlock(ugc_pkg::UNLOCK_KEY ^ 16'h0100);
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk("wlock bad key", 8'h01, {7'b0, wlock});
        mp.unlock(ugc_pkg::UNLOCK_KEY);
        repeat (3) @(posedge i_ref_clk);
        #1;
        chk("wlock unlocked", 8'h00, {7'b0, wlock});
        chk("rlock unlocked", 8'h00, {7'b0, rlock});
        mp.cmd(ugc_pkg::CMD_SCRATCH_RD);
        rd_exp(scr[7:0]);
        rd_exp({3'b000, scr[12:8]});
        $display("lock test done");
        repeat (5) @(posedge i_ref_clk);
        chk("pending reads", 8'h00, 8'(exp_q.size()));
        summarize();
    end
endmodule
`default_nettype wire
